// [hw/rtcp_dev.sv]
`timescale 1ns/1ps
module rtcp_dev #(
  parameter int TIMEOUT_CYCLES = rtcp_pkg::TIMEOUT_MAX_US * rtcp_pkg::CLK_MHZ
) (
  input wire logic clock,
  input wire logic link_clk,
  input wire logic sys_rst,
  rtcp_if.dev bus,
  input wire logic osc_run,
  input wire logic alarm_active,
  input wire logic [rtcp_pkg::BYTE_W-1:0] mem_rdata,
  output logic [rtcp_pkg::BYTE_W-1:0] mem_addr,
  output logic [rtcp_pkg::BYTE_W-1:0] mem_wdata,
  output logic mem_wr,
  output logic mem_rd,
  output logic ext_clock_in_or_alarm_irq_pin_o,
  output logic ext_clock_in_or_alarm_irq_pin_oe
);
  import rtcp_pkg::*;

  localparam logic [TOCNT_W-1:0] TO_LIM = TOCNT_W'(TIMEOUT_CYCLES);

  logic scl_l;
  logic sda_l;
  logic scl_lq;
  logic sda_lq;
  logic scl_c;
  logic to_c;
  logic to_l;
  logic start_ev;
  logic stop_ev;
  logic scl_rise;
  logic scl_fall;
  rtcp_dev_e state;
  logic [3:0] bitcnt;
  logic [BYTE_W-1:0] shreg;
  logic is_read;
  logic got_reg;
  logic wrote;
  logic more;
  logic [TOCNT_W-1:0] to_cnt;

  rtcp_sync u_scl_l (
    .clk(link_clk),
    .rst(sys_rst),
    .d(bus.scl),
    .q(scl_l)
  );

  rtcp_sync u_sda_l (
    .clk(link_clk),
    .rst(sys_rst),
    .d(bus.sda),
    .q(sda_l)
  );

  rtcp_sync u_scl_c (
    .clk(clock),
    .rst(sys_rst),
    .d(bus.scl),
    .q(scl_c)
  );

  rtcp_sync u_to_l (
    .clk(link_clk),
    .rst(sys_rst),
    .d(to_c),
    .q(to_l)
  );

  // Timeout runs on the oscillator clock so a stalled link cannot hide it.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      to_cnt <= '0;
    end else if (!osc_run || scl_c) begin
      to_cnt <= '0;
    end else if (to_cnt != TO_LIM) begin
      to_cnt <= to_cnt + 1'b1;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      to_c <= 1'b0;
    end else begin
      to_c <= osc_run & ~scl_c & (to_cnt == TO_LIM);
    end
  end

  // The alarm pin is open drain: it can only pull low or let go.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ext_clock_in_or_alarm_irq_pin_o <= 1'b0;
      ext_clock_in_or_alarm_irq_pin_oe <= 1'b0;
    end else begin
      ext_clock_in_or_alarm_irq_pin_o <= 1'b0;
      ext_clock_in_or_alarm_irq_pin_oe <= alarm_active;
    end
  end

  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_lq <= 1'b1;
      sda_lq <= 1'b1;
    end else begin
      scl_lq <= scl_l;
      sda_lq <= sda_l;
    end
  end

  assign start_ev = scl_l & scl_lq & sda_lq & ~sda_l;
  assign stop_ev = scl_l & scl_lq & ~sda_lq & sda_l;
  assign scl_rise = scl_l & ~scl_lq;
  assign scl_fall = ~scl_l & scl_lq;

  // The data driver level never leaves zero; only the enable moves.
  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus.dev_sda_o <= 1'b0;
    end else begin
      bus.dev_sda_o <= 1'b0;
    end
  end

  // SCL is only ever sampled here, never driven, so the master sets the pace.
  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= RTCP_D_IDLE;
      bitcnt <= '0;
      shreg <= '0;
      is_read <= 1'b0;
      got_reg <= 1'b0;
      wrote <= 1'b0;
      more <= 1'b0;
      mem_addr <= '0;
      mem_wdata <= '0;
      mem_wr <= 1'b0;
      mem_rd <= 1'b0;
      bus.dev_sda_oe <= 1'b0;
    end else begin
      mem_wr <= 1'b0;
      mem_rd <= 1'b0;
      if (to_l || stop_ev) begin
        state <= RTCP_D_IDLE;
        bus.dev_sda_oe <= 1'b0;
      end else if (start_ev) begin
        state <= RTCP_D_ADDR;
        bitcnt <= '0;
        got_reg <= 1'b0;
        wrote <= 1'b0;
        bus.dev_sda_oe <= 1'b0;
      end else begin
        case (state)
          RTCP_D_ADDR: begin
            if (scl_rise && bitcnt != BIT_LAST) begin
              shreg <= {shreg[BYTE_W-2:0], sda_l};
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == BIT_LAST) begin
              if (shreg[BYTE_W-1:1] == DEV_ADDR7) begin
                is_read <= (shreg[0] == DIR_READ);
                bus.dev_sda_oe <= 1'b1;
                state <= RTCP_D_ACK;
              end else begin
                state <= RTCP_D_IDLE;
              end
            end
          end
          RTCP_D_WRECV: begin
            if (scl_rise && bitcnt != BIT_LAST) begin
              shreg <= {shreg[BYTE_W-2:0], sda_l};
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == BIT_LAST) begin
              bus.dev_sda_oe <= 1'b1;
              state <= RTCP_D_ACK;
              if (got_reg) begin
                mem_wr <= 1'b1;
                mem_wdata <= shreg;
                wrote <= 1'b1;
              end else begin
                mem_addr <= shreg;
                got_reg <= 1'b1;
              end
            end
          end
          RTCP_D_ACK: begin
            if (scl_fall) begin
              if (is_read) begin
                shreg <= mem_rdata;
                bus.dev_sda_oe <= ~mem_rdata[BYTE_W-1];
                bitcnt <= BIT_FIRST_SENT;
                mem_rd <= 1'b1;
                mem_addr <= mem_addr + 1'b1;
                state <= RTCP_D_RSEND;
              end else begin
                bus.dev_sda_oe <= 1'b0;
                bitcnt <= '0;
                state <= RTCP_D_WRECV;
                if (wrote) begin
                  mem_addr <= mem_addr + 1'b1;
                  wrote <= 1'b0;
                end
              end
            end
          end
          RTCP_D_RSEND: begin
            if (scl_fall) begin
              if (bitcnt == BIT_LAST) begin
                bus.dev_sda_oe <= 1'b0;
                state <= RTCP_D_RACK;
              end else begin
                shreg <= {shreg[BYTE_W-2:0], 1'b0};
                bus.dev_sda_oe <= ~shreg[BYTE_W-2];
                bitcnt <= bitcnt + 4'h1;
              end
            end
          end
          RTCP_D_RACK: begin
            if (scl_rise) begin
              more <= ~sda_l;
            end else if (scl_fall) begin
              if (more) begin
                shreg <= mem_rdata;
                bus.dev_sda_oe <= ~mem_rdata[BYTE_W-1];
                bitcnt <= BIT_FIRST_SENT;
                mem_rd <= 1'b1;
                mem_addr <= mem_addr + 1'b1;
                state <= RTCP_D_RSEND;
              end else begin
                // A NACK ends the read; the line stays released until a start.
                state <= RTCP_D_IDLE;
              end
            end
          end
          default: begin
            state <= RTCP_D_IDLE;
          end
        endcase
      end
    end
  end
endmodule : rtcp_dev

// [hw/rtcp_host.sv]
`timescale 1ns/1ps
module rtcp_host (
  input wire logic clock,
  input wire logic sys_rst,
  rtcp_if.host bus,
  input wire logic cmd_valid,
  input wire rtcp_pkg::rtcp_op_e cmd_op,
  input wire logic [rtcp_pkg::BYTE_W-1:0] cmd_data,
  input wire logic cmd_nack,
  output logic cmd_ready,
  output logic done,
  output logic [rtcp_pkg::BYTE_W-1:0] rd_data,
  output logic ack_got
);
  import rtcp_pkg::*;

  logic sda_h;
  rtcp_host_e state;
  rtcp_host_e next_state;
  logic [BYTE_W:0] next_tx;
  logic [BYTE_W:0] tx;
  logic [BYTE_W:0] rx;
  logic [QCNT_W-1:0] qcnt;
  logic [1:0] phase;
  logic [3:0] bitn;
  logic [1:0] lv_now;
  logic [1:0] lv_first;

  // Returns {scl, sda} for one quarter of a bit cell.
  function automatic logic [1:0] phase_lv(input rtcp_host_e st, input logic [1:0] ph, input logic b);
    logic [1:0] r;
    r = 2'h3;
    case (st)
      RTCP_H_START: r = (ph == 2'h0) ? 2'h1 : (ph == 2'h1) ? 2'h3 : (ph == 2'h2) ? 2'h2 : 2'h0;
      RTCP_H_STOP: r = (ph == 2'h0) ? 2'h0 : (ph == 2'h1) ? 2'h2 : 2'h3;
      RTCP_H_BYTE: r = {(ph == 2'h1 || ph == 2'h2), b};
      default: r = 2'h3;
    endcase
    return r;
  endfunction : phase_lv

  rtcp_sync u_sda_h (
    .clk(clock),
    .rst(sys_rst),
    .d(bus.sda),
    .q(sda_h)
  );

  always_comb begin
    next_state = RTCP_H_BYTE;
    if (cmd_op == RTCP_OP_START) begin
      next_state = RTCP_H_START;
    end else if (cmd_op == RTCP_OP_STOP) begin
      next_state = RTCP_H_STOP;
    end
    next_tx = (cmd_op == RTCP_OP_READ) ? {{BYTE_W{1'b1}}, cmd_nack} : {cmd_data, 1'b1};
  end

  assign lv_now = phase_lv(state, phase + 2'h1, (phase == 2'h3) ? tx[BYTE_W-1] : tx[BYTE_W]);

  // Levels of the first quarter of a command, so the take can launch them at once.
  assign lv_first = phase_lv(next_state, 2'h0, next_tx[BYTE_W]);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      bus.host_sda_o <= 1'b0;
    end else begin
      bus.host_sda_o <= 1'b0;
    end
  end

  // SCL is push-pull here, which is safe because the device never stretches it.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state <= RTCP_H_IDLE;
      cmd_ready <= 1'b0;
      done <= 1'b0;
      rd_data <= '0;
      ack_got <= 1'b0;
      tx <= '1;
      rx <= '0;
      qcnt <= '0;
      phase <= 2'h0;
      bitn <= '0;
      bus.scl <= 1'b1;
      bus.host_sda_oe <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        RTCP_H_IDLE: begin
          cmd_ready <= 1'b1;
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            state <= next_state;
            tx <= next_tx;
            qcnt <= '0;
            phase <= 2'h0;
            bitn <= '0;
            bus.scl <= lv_first[1];
            bus.host_sda_oe <= ~lv_first[0];
          end
        end
        default: begin
          if (qcnt != QCNT_LAST) begin
            qcnt <= qcnt + 1'b1;
          end else begin
            qcnt <= '0;
            if (phase == 2'h2) begin
              rx <= {rx[BYTE_W-1:0], sda_h};
            end
            if (phase != 2'h3) begin
              phase <= phase + 2'h1;
              bus.scl <= lv_now[1];
              bus.host_sda_oe <= ~lv_now[0];
            end else if (state == RTCP_H_BYTE && bitn != BIT_LAST) begin
              phase <= 2'h0;
              bitn <= bitn + 4'h1;
              tx <= {tx[BYTE_W-1:0], 1'b1};
              bus.scl <= lv_now[1];
              bus.host_sda_oe <= ~lv_now[0];
            end else begin
              // SCL stays low between bytes; the user must keep ops coming.
              state <= RTCP_H_IDLE;
              done <= 1'b1;
              if (state == RTCP_H_BYTE) begin
                rd_data <= rx[BYTE_W:1];
                ack_got <= ~rx[0];
              end
            end
          end
        end
      endcase
    end
  end
endmodule : rtcp_host

// [hw/rtcp_if.sv]
`timescale 1ns/1ps
interface rtcp_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;

  // Wired-AND with a pull-up: any enabled low driver pulls the line down.
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport host (
    output scl,
    output host_sda_o,
    output host_sda_oe,
    input sda
  );

  modport dev (
    input scl,
    input sda,
    output dev_sda_o,
    output dev_sda_oe
  );
endinterface : rtcp_if

// [hw/rtcp_pkg.sv]
package rtcp_pkg;

  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;

  // SCL rate made by the master's divider; each bit cell is four quarters.
  localparam int SCL_HZ = 250_000;
  localparam int SCL_QUARTER = CLK_HZ / (4 * SCL_HZ);
  localparam int QCNT_W = 5;
  localparam logic [QCNT_W-1:0] QCNT_LAST = QCNT_W'(SCL_QUARTER - 1);

  localparam int BYTE_W = 8;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] BIT_FIRST_SENT = 4'h1;

  // Fixed address byte is D0h for writes and D1h for reads.
  localparam logic [6:0] DEV_ADDR7 = 7'h68;
  localparam logic DIR_READ = 1'b1;

  // Bus timeout interval in microseconds; the figure itself is a plain default.
  localparam int TIMEOUT_MAX_US = 25000;
  localparam int TOCNT_W = 24;

  typedef enum logic [1:0] {
    RTCP_OP_START = 2'h0,
    RTCP_OP_STOP = 2'h1,
    RTCP_OP_WRITE = 2'h2,
    RTCP_OP_READ = 2'h3
  } rtcp_op_e;

  typedef enum logic [5:0] {
    RTCP_D_IDLE = 6'h01,
    RTCP_D_ADDR = 6'h02,
    RTCP_D_ACK = 6'h04,
    RTCP_D_WRECV = 6'h08,
    RTCP_D_RSEND = 6'h10,
    RTCP_D_RACK = 6'h20
  } rtcp_dev_e;

  typedef enum logic [3:0] {
    RTCP_H_IDLE = 4'h1,
    RTCP_H_START = 4'h2,
    RTCP_H_STOP = 4'h4,
    RTCP_H_BYTE = 4'h8
  } rtcp_host_e;

endpackage : rtcp_pkg

// [hw/rtcp_sync.sv]
`timescale 1ns/1ps
module rtcp_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);
  logic meta;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= 1'b0;
      q <= 1'b0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : rtcp_sync

// [testbench/rtcp_checker.sv]
`timescale 1ns/1ps
module rtcp_checker (
  input wire logic clock,
  input wire logic link_clk,
  input wire logic sys_rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe
);
  import rtcp_pkg::*;
  logic scl_q;
  logic sda_q;
  logic first;
  logic [3:0] bitn;
  logic [7:0] shreg;
  wire logic rise = scl & ~scl_q;
  wire logic start = scl & scl_q & sda_q & ~sda;
  wire logic stop = scl & scl_q & ~sda_q & sda;
  wire logic nine = rise & (bitn == BIT_LAST);
  wire logic hit = first & nine & (shreg[7:1] == DEV_ADDR7);
  wire logic miss = first & nine & (shreg[7:1] != DEV_ADDR7);
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end
  // The clock pulse of a repeated start is counted too, but the start clears it again.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      bitn <= 4'h0;
      first <= 1'b0;
    end else if (start) begin
      bitn <= 4'h0;
      first <= 1'b1;
    end else if (nine) begin
      bitn <= 4'h0;
      first <= 1'b0;
    end else if (rise) begin
      bitn <= bitn + 4'h1;
    end
  end
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      shreg <= 8'h00;
    end else if (rise && !nine) begin
      shreg <= {shreg[6:0], sda};
    end
  end
  addr_ack_a: assert property (@(posedge clock) disable iff (sys_rst) hit |-> !sda)
    else $error("matching address byte not acknowledged");
  addr_ignore_a: assert property (@(posedge clock) disable iff (sys_rst) miss |-> sda)
    else $error("foreign address byte acknowledged");
  ack_release_a: assert property (@(posedge clock) disable iff (sys_rst)
    hit && !shreg[0] |-> ##90 !dev_sda_oe [*8]) else $error("acknowledge not released");
  dev_drain_a: assert property (@(posedge clock) disable iff (sys_rst) dev_sda_oe |-> !dev_sda_o)
    else $error("device drives data line high");
  host_drain_a: assert property (@(posedge clock) disable iff (sys_rst) host_sda_oe |-> !host_sda_o)
    else $error("master drives data line high");
  dev_hold_a: assert property (@(posedge link_clk) disable iff (sys_rst)
    scl && $past(scl) |-> $stable(dev_sda_oe)) else $error("device data changed while clock high");
  stop_release_a: assert property (@(posedge clock) disable iff (sys_rst) stop |=> !dev_sda_oe [*8])
    else $error("device drives after stop");
  reset_idle_a: assert property (@(posedge clock) disable iff (sys_rst)
    $fell(sys_rst) |-> scl && !dev_sda_oe) else $error("bus not idle after reset");
  cover property (@(posedge clock) disable iff (sys_rst) start);
  cover property (@(posedge clock) disable iff (sys_rst) hit);
  cover property (@(posedge clock) disable iff (sys_rst) miss);
  cover property (@(posedge clock) disable iff (sys_rst) stop);
endmodule : rtcp_checker

// [testbench/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import rtcp_pkg::*;
  localparam int TO = 2000;
  logic clock = 1'b0;
  logic link_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid = 1'b0;
  rtcp_op_e cmd_op = RTCP_OP_START;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_nack = 1'b0;
  logic osc_run = 1'b0;
  logic alarm_active = 1'b0;
  logic cmd_ready, done, ack_got, mem_wr, mem_rd, irq_o, irq_oe;
  logic [7:0] rd_data, mem_addr, mem_wdata;
  logic [7:0] mem [256];
  wire logic [7:0] mem_rdata = mem[mem_addr];
  int error_cnt = 0;
  int samples_checked = 0;
  int rd_cnt = 0;
  rtcp_if bus_if ();
  rtcp_host rtcp_host_i (.clock(clock), .sys_rst(sys_rst), .bus(bus_if.host), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_nack(cmd_nack), .cmd_ready(cmd_ready), .done(done),
    .rd_data(rd_data), .ack_got(ack_got));
  rtcp_dev #(.TIMEOUT_CYCLES(TO)) rtcp_dev_i (.clock(clock), .link_clk(link_clk), .sys_rst(sys_rst),
    .bus(bus_if.dev), .osc_run(osc_run), .alarm_active(alarm_active), .mem_rdata(mem_rdata),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wr(mem_wr), .mem_rd(mem_rd),
    .ext_clock_in_or_alarm_irq_pin_o(irq_o), .ext_clock_in_or_alarm_irq_pin_oe(irq_oe));
  rtcp_checker rtcp_checker_i (.clock(clock), .link_clk(link_clk), .sys_rst(sys_rst), .scl(bus_if.scl),
    .sda(bus_if.sda), .host_sda_o(bus_if.host_sda_o), .host_sda_oe(bus_if.host_sda_oe),
    .dev_sda_o(bus_if.dev_sda_o), .dev_sda_oe(bus_if.dev_sda_oe));
  initial begin
    forever #20 clock = ~clock;
  end
  // The link clock starts off phase so that no edge of it meets an edge of the system clock.
  initial begin
    #7;
    forever #40 link_clk = ~link_clk;
  end
  always @(posedge link_clk) begin
    if (mem_wr === 1'b1) begin
      mem[mem_addr] <= mem_wdata;
    end
    if (mem_rd === 1'b1) begin
      rd_cnt <= rd_cnt + 1;
    end
  end
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic op(input rtcp_op_e o, input logic [7:0] d, input logic n);
    int k;
    k = 0;
    do @(posedge clock); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b1;
    cmd_op <= o;
    cmd_data <= d;
    cmd_nack <= n;
    @(posedge clock);
    cmd_valid <= 1'b0;
    while (done !== 1'b1 && k < 1200) begin
      @(posedge clock);
      k++;
    end
    // A command that never completes is a failure in its own right.
    if (done !== 1'b1) begin
      error_cnt++;
      print_verdict();
    end
  endtask : op
  task automatic wb(input logic [7:0] d, input logic acked);
    op(RTCP_OP_WRITE, d, 1'b0);
    check({7'h00, ack_got}, {7'h00, acked});
  endtask : wb
  task automatic rb(input logic n, input logic [7:0] exp);
    op(RTCP_OP_READ, 8'h00, n);
    check(rd_data, exp);
  endtask : rb
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h3c;
    end
    repeat (2) @(posedge link_clk);
    @(posedge clock);
    sys_rst <= 1'b0;
    osc_run <= 1'b1;
    repeat (20) @(posedge clock);
    op(RTCP_OP_START, 8'h00, 1'b0);
    wb(8'hd0, 1'b1);
    wb(8'h10, 1'b1);
    wb(8'ha5, 1'b1);
    wb(8'h5a, 1'b1);
    op(RTCP_OP_STOP, 8'h00, 1'b0);
    check(mem[8'h10], 8'ha5);
    check(mem[8'h11], 8'h5a);
    op(RTCP_OP_START, 8'h00, 1'b0);
    wb(8'hd0, 1'b1);
    wb(8'h10, 1'b1);
    op(RTCP_OP_START, 8'h00, 1'b0);
    wb(8'hd1, 1'b1);
    rb(1'b0, 8'ha5);
    rb(1'b1, 8'h5a);
    op(RTCP_OP_STOP, 8'h00, 1'b0);
    check(mem_addr, 8'h12);
    check(8'(rd_cnt), 8'h02);
    op(RTCP_OP_START, 8'h00, 1'b0);
    wb(8'hd1, 1'b1);
    rb(1'b1, 8'h12 ^ 8'h3c);
    op(RTCP_OP_STOP, 8'h00, 1'b0);
    op(RTCP_OP_START, 8'h00, 1'b0);
    wb(8'ha0, 1'b0);
    wb(8'h10, 1'b0);
    wb(8'h77, 1'b0);
    op(RTCP_OP_STOP, 8'h00, 1'b0);
    check(mem[8'h10], 8'ha5);
    check(mem_addr, 8'h13);
    // Read byte 7ch from 40h so that the device holds the data line low while the clock rests.
    op(RTCP_OP_START, 8'h00, 1'b0);
    wb(8'hd0, 1'b1);
    wb(8'h40, 1'b1);
    op(RTCP_OP_START, 8'h00, 1'b0);
    wb(8'hd1, 1'b1);
    osc_run <= 1'b0;
    repeat (TO + 500) @(posedge clock);
    check({7'h00, bus_if.dev_sda_oe}, 8'h01);
    osc_run <= 1'b1;
    repeat (TO + 500) @(posedge clock);
    check({7'h00, bus_if.dev_sda_oe}, 8'h00);
    check({7'h00, bus_if.sda}, 8'h01);
    op(RTCP_OP_START, 8'h00, 1'b0);
    wb(8'hd0, 1'b1);
    op(RTCP_OP_STOP, 8'h00, 1'b0);
    alarm_active <= 1'b1;
    repeat (2) @(posedge clock);
    check({6'h00, irq_oe, irq_o}, 8'h02);
    alarm_active <= 1'b0;
    repeat (2) @(posedge clock);
    check({6'h00, irq_oe, irq_o}, 8'h00);
    print_verdict();
  end
  initial begin
    repeat (40000) @(posedge clock);
    error_cnt++;
    print_verdict();
  end
endmodule : testbench
